/* File: shared/wdt_halt_pkg.sv */
// Constants, register map and state types of the watchdog and halt/wake-up block
package wdt_halt_pkg;

   // Data-memory register addresses
   localparam logic [6:0] WATCHDOG_PRESCALE_SELECT_ADDR   = 7'h09;
   localparam logic [6:0] STATUS_ADDR = 7'h0A;
   localparam logic [6:0] INTERRUPT_CONTROL_ADDR   = 7'h0B;

   // Field positions
   localparam int PDF_BIT = 4;
   localparam int TO_BIT  = 5;
   localparam int EMI_BIT = 0;
   localparam int EEI_BIT = 1;
   localparam int ETI_BIT = 2;
   localparam int EIF_BIT = 4;
   localparam int TF_BIT  = 5;

   // Values after reset
   localparam logic [7:0] WATCHDOG_PRESCALE_SELECT_RST = 8'h07;

   // Cycle counts
   localparam int         STARTUP_CYC = 1024;   // Start-up delay in system clocks
   localparam logic [7:0] BASE_LAST   = 8'hFF;  // Last count of the fixed /256 stage
   localparam logic [1:0] IDIV_LAST   = 2'h3;   // System clock / 4 instruction clock
   localparam logic [1:0] IDIV_HALF   = 2'h1;

   // Watchdog clock source options
   localparam logic [1:0] SRC_WDT_OSC = 2'h0;
   localparam logic [1:0] SRC_RTC     = 2'h1;
   localparam logic [1:0] SRC_INSTR   = 2'h2;

   typedef enum logic [1:0] {ST_STARTUP, ST_RUN, ST_HALT} mode_t;

   // Mask options fixed at build time
   typedef struct packed {
      logic       wdt_en;       // Watchdog enabled
      logic [1:0] wdt_src;      // Watchdog clock source
      logic       pair_mode;    // Two distinct kick instructions needed
      logic       rc_osc;       // External RC system oscillator chosen
      logic       rtc_en;       // Real-time crystal oscillator enabled
      logic       wdt_osc_en;   // Dedicated watchdog oscillator enabled
      logic [7:0] pa_wake;      // Port A wake-up enables
   } opt_t;

   // One-cycle instruction events from the core
   typedef struct packed {
      logic kick_single_instr;
      logic kick_first_half;
      logic kick_second_half;
      logic halt_instr;
   } evt_t;

   // Whole state of the block
   typedef struct packed {
      mode_t       state;
      logic [10:0] sup_cnt;
      logic [7:0]  pre_cnt;
      logic [6:0]  ratio_cnt;
      logic        kick1;
      logic        kick2;
      logic [1:0]  idiv;
      logic        clkout;
      logic [7:0]  watchdog_prescale_select;
      logic        master_irq_enable;
      logic        ext_irq_enable;
      logic        timer_irq_enable;
      logic        ext_irq_flag;
      logic        tf;
      logic        powerdown_flag;
      logic        to;
      logic [1:0]  halt_mask;
      logic [7:0]  pa_prev;
      logic        chip_rst;
      logic        warm_rst;
      logic [1:0]  svc;
      logic [7:0]  rd_data;
   } st_t;

endpackage : wdt_halt_pkg

/* File: rtl/wdt_halt_wake.sv */
// Watchdog timer, halt and wake-up control with interrupt request and enable bits
//
// Summary of operation
// - Request flags stay set until serviced, cleared by software, or cleared by a pin or watchdog chip reset.
// - Master, external and timer enables all gate servicing of a request.
// - External RC option drives the clock pin at system clock over four.
// - Watchdog clock chosen from its oscillator, crystal clock or instruction clock.
// - With the watchdog disabled, counting, overflow and kicks do nothing; halt still sets power-down and clears expired.
// - Watchdog clock first divided by 256 for the base period.
// - Prescale bits 2..0 add division 1:1 up to 1:128, doubling per step.
// - Prescale bit 3 and bits 7..4 are plain user storage.
// - Overflow while running gives a chip reset and sets the expired flag.
// - Overflow while halted gives a warm reset and wakes the device.
// - Reset pin, kick instructions and halt clear watchdog and prescaler.
// - Single mode: one kick clears; paired mode: both distinct kicks needed.
// - Halt stops system clock; watchdog oscillator keeps counting from cleared.
// - Halt keeps state, sets power-down flag, clears expired flag.
// - Instruction-clocked watchdog stops in halt; a reset, interrupt or port A wake-up restarts it.
// - Halt exits by reset, interrupt, port A falling edge or overflow.
// - Each port A pin selectable as wake source; resumes after halt.
// - Interrupt wake services only if enabled and stack not full.
// - A request already set at halt entry does not wake that halt.
// - Every wake-up waits 1024 system clocks before execution resumes.
// - Power-down flag cleared by power-up or kick, set only by halt.
// - An enabled crystal oscillator keeps counting the watchdog in halt.
// - Status bits 4 and 5 hold the flags; writes do not alter them.
// - Reset and wake-up both add a 1024-clock start-up delay.

`timescale 1ns/100ps
`default_nettype none

module wdt_halt_wake
   import wdt_halt_pkg::*;
(
   input  wire logic       mclk_i,        // System clock, 50 MHz
   input  wire logic       rst_n_i,       // Reset pin, synchronous, active low
   input  wire opt_t       opt_i,         // Build-time options
   input  wire evt_t       evt_i,         // Instruction events, one-cycle pulses
   input  wire logic       wdt_osc_tick_i, // Watchdog oscillator tick
   input  wire logic       rtc_tick_i,    // Crystal oscillator tick
   input  wire logic       ext_irq_i,     // External interrupt event pulse
   input  wire logic       timer_irq_i,   // Timer overflow event pulse
   input  wire logic       stack_full_i,  // Stack has no free level
   input  wire logic [7:0] pa_i,          // Port A pin levels
   input  wire logic [6:0] addr_i,        // Data-memory address
   input  wire logic       wr_i,          // Write strobe
   input  wire logic [7:0] wdata_i,       // Write data
   output logic      [7:0] rdata_o,       // Read data, one cycle after address
   output logic            run_o,         // Core may execute
   output logic            halted_o,      // System oscillator stopped
   output logic            chip_rst_o,    // Watchdog chip reset pulse
   output logic            warm_rst_o,    // Program counter and stack pointer reset pulse
   output logic      [1:0] svc_o,         // Service pulse: bit0 external, bit1 timer
   output logic            clkout_pin_o   // Clock output pin
);

   st_t        st_q;
   st_t        st_d;
   logic       wtick;
   logic       itick;
   logic       ovf;
   logic       kick;
   logic       wr_interrupt_control;
   logic [6:0] ratio_lim;
   logic [7:0] pa_fall;
   logic       irq_wake;
   logic       wake;

   ////////////////////////////////////////////////////////////////////////////
   // Watchdog clock selection and overflow detection
   always_comb
   begin
      itick     = (st_q.idiv == IDIV_LAST) && (st_q.state != ST_HALT);
      case (opt_i.wdt_src)
         SRC_WDT_OSC: wtick = wdt_osc_tick_i && opt_i.wdt_osc_en;
         SRC_RTC:     wtick = rtc_tick_i && opt_i.rtc_en;
         SRC_INSTR:   wtick = itick;
         default:     wtick = 1'b0;
      endcase
      ratio_lim = 7'((8'h01 << st_q.watchdog_prescale_select[2:0]) - 8'h01);
      ovf       = opt_i.wdt_en && wtick && (st_q.pre_cnt == BASE_LAST)
                  && (st_q.ratio_cnt == ratio_lim);
      wr_interrupt_control   = wr_i && (addr_i == INTERRUPT_CONTROL_ADDR);
      pa_fall   = st_q.pa_prev & ~pa_i & opt_i.pa_wake;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Next state of the whole block
   always_comb
   begin
      st_d          = st_q;
      st_d.chip_rst = 1'b0;
      st_d.warm_rst = 1'b0;
      st_d.svc      = 2'b00;
      st_d.pa_prev  = pa_i;
      kick          = 1'b0;
      irq_wake      = 1'b0;
      wake          = 1'b0;

      // Instruction clock divider and clock pin
      if (st_q.state != ST_HALT)
      begin
         st_d.idiv = st_q.idiv + 2'h1;
         if ((st_q.idiv == IDIV_HALF) || (st_q.idiv == IDIV_LAST))
            st_d.clkout = ~st_q.clkout & opt_i.rc_osc;
      end

      // Watchdog counting: fixed /256 stage then ratio stage
      if (opt_i.wdt_en && wtick)
      begin
         st_d.pre_cnt = st_q.pre_cnt + 8'h01;
         if (st_q.pre_cnt == BASE_LAST)
            st_d.ratio_cnt = (st_q.ratio_cnt == ratio_lim) ? 7'h00
                             : st_q.ratio_cnt + 7'h01;
      end

      // Register writes; status flags ignore writes
      if (wr_i && (addr_i == WATCHDOG_PRESCALE_SELECT_ADDR))
         st_d.watchdog_prescale_select = wdata_i;
      if (wr_interrupt_control)
      begin
         st_d.master_irq_enable = wdata_i[EMI_BIT];
         st_d.ext_irq_enable = wdata_i[EEI_BIT];
         st_d.timer_irq_enable = wdata_i[ETI_BIT];
         st_d.ext_irq_flag = wdata_i[EIF_BIT];
         st_d.tf  = wdata_i[TF_BIT];
      end

      // Requests set last so an event wins over a clearing write
      if (st_q.state == ST_RUN && !stack_full_i && st_q.master_irq_enable)
      begin
         if (st_q.ext_irq_flag && st_q.ext_irq_enable)
         begin
            st_d.svc = 2'b01;
            st_d.ext_irq_flag = 1'b0;
            st_d.master_irq_enable = 1'b0;
         end
         else if (st_q.tf && st_q.timer_irq_enable)
         begin
            st_d.svc = 2'b10;
            st_d.tf  = 1'b0;
            st_d.master_irq_enable = 1'b0;
         end
      end
      if (ext_irq_i)
         st_d.ext_irq_flag = 1'b1;
      if (timer_irq_i)
         st_d.tf = 1'b1;

      // Kick instructions, single or paired
      if (opt_i.wdt_en && st_q.state == ST_RUN)
      begin
         if (!opt_i.pair_mode)
            kick = evt_i.kick_single_instr;
         else
         begin
            st_d.kick1 = st_q.kick1 | evt_i.kick_first_half;
            st_d.kick2 = st_q.kick2 | evt_i.kick_second_half;
            kick = st_d.kick1 && st_d.kick2;
         end
      end
      if (kick)
      begin
         st_d.pre_cnt   = 8'h00;
         st_d.ratio_cnt = 7'h00;
         st_d.kick1     = 1'b0;
         st_d.kick2     = 1'b0;
         st_d.powerdown_flag       = 1'b0;
         st_d.to        = 1'b0;
      end

      // Operating mode sequence
      case (st_q.state)
         ST_STARTUP:
         begin
            st_d.sup_cnt = st_q.sup_cnt + 11'h001;
            if (st_q.sup_cnt == 11'(STARTUP_CYC - 1))
            begin
               st_d.state   = ST_RUN;
               st_d.sup_cnt = 11'h000;
            end
         end
         ST_RUN:
         begin
            if (ovf)
            begin
               st_d           = st_q;  // Chip reset returns control bits to reset values
               st_d.idiv      = st_q.idiv + 2'h1;
               st_d.clkout    = 1'b0;
               st_d.pa_prev   = pa_i;
               st_d.state     = ST_STARTUP;
               st_d.sup_cnt   = 11'h000;
               st_d.pre_cnt   = 8'h00;
               st_d.ratio_cnt = 7'h00;
               st_d.kick1     = 1'b0;
               st_d.kick2     = 1'b0;
               st_d.watchdog_prescale_select      = WATCHDOG_PRESCALE_SELECT_RST;
               {st_d.master_irq_enable, st_d.ext_irq_enable, st_d.timer_irq_enable, st_d.ext_irq_flag, st_d.tf} = 5'h00;
               st_d.to        = 1'b1;
               st_d.chip_rst  = 1'b1;
               st_d.svc       = 2'b00;
            end
            else if (evt_i.halt_instr)
            begin
               st_d.state     = ST_HALT;
               st_d.pre_cnt   = 8'h00;
               st_d.ratio_cnt = 7'h00;
               st_d.kick1     = 1'b0;
               st_d.kick2     = 1'b0;
               st_d.powerdown_flag       = 1'b1;
               st_d.to        = 1'b0;
               st_d.halt_mask = {st_d.tf, st_d.ext_irq_flag};
               st_d.clkout    = 1'b0;
            end
         end
         ST_HALT:
         begin
            irq_wake = (ext_irq_i && !st_q.halt_mask[0])
                       || (timer_irq_i && !st_q.halt_mask[1]);
            wake     = irq_wake || (pa_fall != 8'h00) || ovf;
            if (ovf)
            begin
               st_d.to       = 1'b1;
               st_d.warm_rst = 1'b1;
            end
            if (wake)
            begin
               st_d.state   = ST_STARTUP;
               st_d.sup_cnt = 11'h000;
            end
         end
         default:
            st_d.state = ST_STARTUP;
      endcase

      // Register read data
      case (addr_i)
         WATCHDOG_PRESCALE_SELECT_ADDR:   st_d.rd_data = st_q.watchdog_prescale_select;
         STATUS_ADDR: st_d.rd_data = {2'b00, st_q.to, st_q.powerdown_flag, 4'h0};
         INTERRUPT_CONTROL_ADDR:   st_d.rd_data = {2'b00, st_q.tf, st_q.ext_irq_flag, 1'b0,
                                      st_q.timer_irq_enable, st_q.ext_irq_enable, st_q.master_irq_enable};
         default:     st_d.rd_data = 8'h00;
      endcase

      // Reset pin initialises everything and starts the start-up delay
      if (!rst_n_i)
      begin
         st_d      = '0;
         st_d.watchdog_prescale_select = WATCHDOG_PRESCALE_SELECT_RST;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register
   always_ff @(posedge mclk_i)
   begin
      st_q <= st_d;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs straight from state flip-flops
   assign rdata_o      = st_q.rd_data;
   assign run_o        = (st_q.state == ST_RUN);
   assign halted_o     = (st_q.state == ST_HALT);
   assign chip_rst_o   = st_q.chip_rst;
   assign warm_rst_o   = st_q.warm_rst;
   assign svc_o        = st_q.svc;
   assign clkout_pin_o = st_q.clkout;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rst_n_i);

   flag_hold_a: assert property (st_q.ext_irq_flag && !wr_interrupt_control && !(run_o && (ovf
                                || (st_q.master_irq_enable && st_q.ext_irq_enable && !stack_full_i))) |=> st_q.ext_irq_flag)
      else $error("external request flag dropped");
   svc_gate_a: assert property ($rose(svc_o[1]) |-> $past(st_q.master_irq_enable && st_q.timer_irq_enable && st_q.tf))
      else $error("timer serviced without enables");
   clk_div_a: assert property ($rose(clkout_pin_o) && opt_i.rc_osc && run_o ##1 run_o
                              |-> ##1 $fell(clkout_pin_o))
      else $error("clock pin not system clock over four");
   ovf_base_a: assert property ($rose(chip_rst_o) |-> $past(st_q.pre_cnt) == BASE_LAST
                              && st_q.to && st_q.state == ST_STARTUP)
      else $error("chip reset without full base count");
   halt_flags_a: assert property (run_o && evt_i.halt_instr && !ovf
                                |=> halted_o && st_q.powerdown_flag && !st_q.to
                                && st_q.pre_cnt == 8'h00)
      else $error("halt entry flags wrong");
   wdt_off_a: assert property (!opt_i.wdt_en && !evt_i.halt_instr |=> $stable(st_q.powerdown_flag)
                             && !chip_rst_o && !warm_rst_o)
      else $error("disabled watchdog acted");
   start_len_a: assert property ($rose(run_o) |-> $past(st_q.sup_cnt) == 11'(STARTUP_CYC - 1))
      else $error("start-up delay wrong length");
   warm_a: assert property (warm_rst_o |-> $past(halted_o) && st_q.to
                          && st_q.state == ST_STARTUP)
      else $error("warm reset outside halt");
   pa_wake_a: assert property (halted_o && (pa_fall != 8'h00) |=> st_q.state == ST_STARTUP)
      else $error("port A edge did not wake");

   wake_pa_c:   cover property (halted_o ##1 (pa_fall != 8'h00) ##1 !halted_o);
   // Interrupt wake-up, split at mid start-up to keep each range short
   wake_irq_c:  cover property (halted_o && irq_wake ##[1:600] st_q.sup_cnt == 11'h200
                                ##[1:600] $rose(run_o) ##[1:8] svc_o != 2'b00);
   chip_rst_c:  cover property (chip_rst_o);
   warm_rst_c:  cover property (warm_rst_o);

endmodule : wdt_halt_wake

`default_nettype wire

/* File: sim/tb_wdt_halt_wake.sv */
// Self-checking bench for the watchdog, halt and wake-up block
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin error_cnt++; \
   $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, (a), (b)); end end

module tb_wdt_halt_wake
   import wdt_halt_pkg::*;
;
   localparam logic [3:0] K1 = 4'h8, KF = 4'h4, KS = 4'h2, HLT = 4'h1;

   logic       mclk, rst_n, rtc_tick, ext_irq, timer_irq, stack_full, wr;
   logic       run, halted, chip_rst, warm_rst, clkout;
   logic [1:0] svc;
   logic [6:0] addr;
   logic [7:0] pa, wdata, rdata;
   opt_t       opt;
   evt_t       evt;
   int         error_cnt = 0, total_checks = 0, n_chip = 0, n_warm = 0, n_sx = 0, n_st = 0;
   int         c0, k;

   ////////////////////////////////////////////////////////////////////////////////
   // Design under test; both slow oscillators share the bench tick
   wdt_halt_wake DUT (.mclk_i(mclk), .rst_n_i(rst_n), .opt_i(opt), .evt_i(evt),
      .wdt_osc_tick_i(rtc_tick), .rtc_tick_i(rtc_tick), .ext_irq_i(ext_irq),
      .timer_irq_i(timer_irq), .stack_full_i(stack_full), .pa_i(pa), .addr_i(addr),
      .wr_i(wr), .wdata_i(wdata), .rdata_o(rdata), .run_o(run), .halted_o(halted),
      .chip_rst_o(chip_rst), .warm_rst_o(warm_rst), .svc_o(svc), .clkout_pin_o(clkout));

   // System clock, 20 ns period
   initial
   begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end

   // Count the one-cycle pulses of the block
   always @(posedge mclk)
   begin
      if (chip_rst === 1'b1) n_chip++;
      if (warm_rst === 1'b1) n_warm++;
      if (svc[0] === 1'b1) n_sx++;
      if (svc[1] === 1'b1) n_st++;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Bus, event and tick helpers, all driven at the falling edge
   task cyc(input int n);
      repeat (n) @(negedge mclk);
   endtask : cyc

   task wr_reg(input logic [6:0] a, input logic [7:0] d);
      @(negedge mclk);
      addr = a; wdata = d; wr = 1'b1;
      @(negedge mclk);
      wr = 1'b0;
   endtask : wr_reg

   task rd_chk(input logic [6:0] a, input logic [7:0] e);
      @(negedge mclk);
      addr = a;
      @(negedge mclk);
      `CHK(rdata, e)
   endtask : rd_chk

   task ev(input logic [3:0] v);
      @(negedge mclk);
      evt = evt_t'(v);
      @(negedge mclk);
      evt = '0;
   endtask : ev

   task ticks(input int n);
      repeat (n)
      begin
         @(negedge mclk);
         rtc_tick = 1'b1;
         @(negedge mclk);
         rtc_tick = 1'b0;
      end
   endtask : ticks

   // Wait for the core to be let run, bounded
   task wait_run();
      k = 0;
      while (run !== 1'b1 && k < 2000)
      begin
         @(negedge mclk);
         k++;
      end
      `CHK(run, 1'b1)
   endtask : wait_run

   task do_reset();
      rst_n = 1'b0;
      cyc(16);
      rst_n = 1'b1;
      wait_run();
      `CHK(k >= 1024 && k <= 1026, 1'b1)
   endtask : do_reset

   ////////////////////////////////////////////////////////////////////////////////
   // Scenarios
   task t_regs();
      rd_chk(WATCHDOG_PRESCALE_SELECT_ADDR, 8'h07);
      rd_chk(STATUS_ADDR, 8'h00);
      rd_chk(INTERRUPT_CONTROL_ADDR, 8'h00);
      rd_chk(7'h20, 8'h00);
      wr_reg(WATCHDOG_PRESCALE_SELECT_ADDR, 8'hA5);
      rd_chk(WATCHDOG_PRESCALE_SELECT_ADDR, 8'hA5);
      wr_reg(STATUS_ADDR, 8'hFF);
      rd_chk(STATUS_ADDR, 8'h00);
      c0 = 0;
      @(negedge mclk);
      for (int i = 0; i < 40; i++)
      begin
         k = clkout;
         @(negedge mclk);
         if (k == 0 && clkout === 1'b1) c0++;
      end
      `CHK(c0, 10)
   endtask : t_regs

   task t_irq();
      wr_reg(INTERRUPT_CONTROL_ADDR, 8'h03);
      @(negedge mclk) ext_irq = 1'b1;
      @(negedge mclk) ext_irq = 1'b0;
      cyc(4);
      `CHK(n_sx, 1)
      rd_chk(INTERRUPT_CONTROL_ADDR, 8'h02);
      @(negedge mclk) timer_irq = 1'b1;
      @(negedge mclk) timer_irq = 1'b0;
      cyc(6);
      rd_chk(INTERRUPT_CONTROL_ADDR, 8'h22);
      stack_full = 1'b1;
      wr_reg(INTERRUPT_CONTROL_ADDR, 8'h25);
      cyc(6);
      `CHK(n_st, 0)
      stack_full = 1'b0;
      cyc(4);
      `CHK(n_st, 1)
      rd_chk(INTERRUPT_CONTROL_ADDR, 8'h04);
   endtask : t_irq

   // Overflow after 256 times the ratio, for the first three ratios
   task t_ratio();
      for (int ws = 0; ws < 3; ws++)
      begin
         wr_reg(WATCHDOG_PRESCALE_SELECT_ADDR, 8'(ws));
         ev(K1);
         c0 = n_chip;
         ticks((256 << ws) - 1);
         `CHK(n_chip, c0)
         ticks(1);
         cyc(2);
         `CHK(n_chip, c0 + 1)
         `CHK(run, 1'b0)
         rd_chk(STATUS_ADDR, 8'h20);
         rd_chk(WATCHDOG_PRESCALE_SELECT_ADDR, 8'h07);
         wait_run();
      end
   endtask : t_ratio

   task t_kick();
      wr_reg(WATCHDOG_PRESCALE_SELECT_ADDR, 8'h00);
      c0 = n_chip;
      ticks(200);
      ev(K1);
      ticks(200);
      `CHK(n_chip, c0)
      rd_chk(STATUS_ADDR, 8'h00);
   endtask : t_kick

   task t_halt();
      ev(HLT);
      `CHK(halted, 1'b1)
      rd_chk(STATUS_ADDR, 8'h10);
      pa = 8'hFD;
      cyc(3);
      `CHK(halted, 1'b1)
      pa = 8'hFC;
      cyc(2);
      `CHK(halted, 1'b0)
      `CHK(run, 1'b0)
      wait_run();
      `CHK(k >= 1020 && k <= 1026, 1'b1)
      pa = 8'hFF;
      ev(HLT);
      c0 = n_chip;
      ticks(255);
      `CHK(n_warm, 0)
      ticks(1);
      cyc(2);
      `CHK(n_warm, 1)
      `CHK(n_chip, c0)
      rd_chk(STATUS_ADDR, 8'h30);
      rd_chk(WATCHDOG_PRESCALE_SELECT_ADDR, 8'h00);
      wait_run();
      wr_reg(INTERRUPT_CONTROL_ADDR, 8'h03);
      ev(HLT);
      @(negedge mclk) ext_irq = 1'b1;
      @(negedge mclk) ext_irq = 1'b0;
      cyc(2);
      `CHK(halted, 1'b0)
      wait_run();
      cyc(4);
      `CHK(n_sx, 2)
   endtask : t_halt

   task t_pair();
      opt.pair_mode = 1'b1;
      do_reset();
      wr_reg(WATCHDOG_PRESCALE_SELECT_ADDR, 8'h00);
      c0 = n_chip;
      ticks(200);
      ev(KF);
      ticks(56);
      cyc(2);
      `CHK(n_chip, c0 + 1)
      wait_run();
      wr_reg(WATCHDOG_PRESCALE_SELECT_ADDR, 8'h00);
      ticks(200);
      ev(KF | KS);
      ticks(255);
      `CHK(n_chip, c0 + 1)
      opt.wdt_en = 1'b0;
      do_reset();
      wr_reg(WATCHDOG_PRESCALE_SELECT_ADDR, 8'h00);
      ticks(300);
      `CHK(n_chip, c0 + 1)
   endtask : t_pair

   // Instruction clock and watchdog oscillator as watchdog sources
   task t_src();
      opt = '{wdt_en: 1'b1, wdt_src: SRC_INSTR, pair_mode: 1'b0, rc_osc: 1'b1,
              rtc_en: 1'b1, wdt_osc_en: 1'b1, pa_wake: 8'h01};
      do_reset();
      wr_reg(WATCHDOG_PRESCALE_SELECT_ADDR, 8'h00);
      ev(K1);
      c0 = n_chip;
      cyc(1000);
      `CHK(n_chip, c0)
      cyc(40);
      `CHK(n_chip, c0 + 1)
      wait_run();
      wr_reg(WATCHDOG_PRESCALE_SELECT_ADDR, 8'h00);
      ev(HLT);
      c0 = n_warm;
      cyc(1100);
      `CHK(halted, 1'b1)
      `CHK(n_warm, c0)
      opt.wdt_src = SRC_WDT_OSC;
      do_reset();
      wr_reg(WATCHDOG_PRESCALE_SELECT_ADDR, 8'h00);
      ev(HLT);
      c0 = n_warm;
      ticks(256);
      cyc(2);
      `CHK(n_warm, c0 + 1)
      wait_run();
      opt.wdt_osc_en = 1'b0;
      ev(K1);
      c0 = n_chip;
      ticks(300);
      `CHK(n_chip, c0)
   endtask : t_src

   ////////////////////////////////////////////////////////////////////////////////
   // Verdict and end of run
   task close_out();
      $display("Checks made %0d, mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : close_out

   // Main sequence
   initial
   begin
      rst_n = 1'b0; rtc_tick = 1'b0; ext_irq = 1'b0; timer_irq = 1'b0;
      stack_full = 1'b0; wr = 1'b0; addr = '0; wdata = '0; pa = 8'hFF; evt = '0;
      opt = '{wdt_en: 1'b1, wdt_src: SRC_RTC, pair_mode: 1'b0, rc_osc: 1'b1,
              rtc_en: 1'b1, wdt_osc_en: 1'b1, pa_wake: 8'h01};
      do_reset();
      t_regs();
      t_irq();
      t_ratio();
      t_kick();
      t_halt();
      t_pair();
      t_src();
      close_out();
   end

   // Watchdog on the run itself
   initial
   begin
      #2_000_000;
      error_cnt++;
      close_out();
   end

endmodule : tb_wdt_halt_wake
`default_nettype wire
